//--- spoc_monitor.sv
// Checker of pin ownership, pull-ups and controller transitions at the block's ports.
`timescale 1ns/1ps
module spoc_monitor #(
  parameter logic RESERVE_JTAG   = spoc_pkg::MODE_FLEXIBLE,
  parameter logic RESERVE_TRST   = 1'b0,
  parameter logic TRST_USER_USED = 1'b0
) (
  input wire logic                       ref_clk_in,
  input wire logic                       arst_n_in,
  input wire spoc_pkg::spoc_pin_drv_type tck_user_in,
  input wire spoc_pkg::spoc_pad_type     tck_pad_out,
  input wire spoc_pkg::spoc_pad_type     tdi_pad_out,
  input wire spoc_pkg::spoc_pad_type     trst_pad_out,
  input wire logic                       tms_pullup_out,
  input wire logic                       tdi_pullup_out,
  input wire logic                       trst_pullup_out,
  input wire logic                       scan_owned_out,
  input wire spoc_pkg::spoc_scan_ctl_type scan_ctl_out,
  input wire spoc_pkg::spoc_tap_state_type tap_state_out
);
  localparam logic DED = (RESERVE_JTAG == spoc_pkg::MODE_DEDICATED);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_pull; $past(arst_n_in) |-> tms_pullup_out == DED && tdi_pullup_out == DED; endproperty
  a_pull: assert property (p_pull) else $error("pull-up level wrong");
  property p_trst_pull; $past(arst_n_in) |-> trst_pullup_out == RESERVE_TRST; endproperty
  a_trst_pull: assert property (p_trst_pull) else $error("reset pin pull-up wrong");
  property p_owned;
    $past(arst_n_in) |-> scan_owned_out == (DED || tap_state_out != spoc_pkg::TAP_TLR);
  endproperty
  a_owned: assert property (p_owned) else $error("ownership wrong");
  property p_tlr_flag;
    $past(arst_n_in) |-> scan_ctl_out.tap_reset == (tap_state_out == spoc_pkg::TAP_TLR);
  endproperty
  a_tlr_flag: assert property (p_tlr_flag) else $error("reset strobe wrong");
  property p_release;
    scan_owned_out |-> tck_pad_out.oe_n && tdi_pad_out.oe_n;
  endproperty
  a_release: assert property (p_release) else $error("pad driven while scan-owned");
  property p_user;
    $past(arst_n_in) && !scan_owned_out && !$past(scan_owned_out)
      |-> tck_pad_out.oe_n == !$past(tck_user_in.oe);
  endproperty
  a_user: assert property (p_user) else $error("user drive not passed");
  property p_enter; $rose(scan_owned_out) && !DED |-> tap_state_out == spoc_pkg::TAP_RTI; endproperty
  a_enter: assert property (p_enter) else $error("scan entry state wrong");
  property p_leave;
    $fell(scan_owned_out) && !RESERVE_TRST |-> $past(tap_state_out) == spoc_pkg::TAP_SEL_IR;
  endproperty
  a_leave: assert property (p_leave) else $error("scan exit path wrong");
  property p_trst_pad; !TRST_USER_USED |-> trst_pad_out.oe_n == spoc_pkg::OE_N_RELEASE; endproperty
  a_trst_pad: assert property (p_trst_pad) else $error("unused reset pad driven");
endmodule
bind spoc_top spoc_monitor #(.RESERVE_JTAG(RESERVE_JTAG), .RESERVE_TRST(RESERVE_TRST),
  .TRST_USER_USED(TRST_USER_USED)) i_mon (.ref_clk_in, .arst_n_in, .tck_user_in, .tck_pad_out,
  .tdi_pad_out, .trst_pad_out, .tms_pullup_out, .tdi_pullup_out, .trst_pullup_out,
  .scan_owned_out, .scan_ctl_out, .tap_state_out);

//--- spoc_pkg.sv
// Package with the states, pin carriers and constants of the scan pin ownership control.
package spoc_pkg;

  // Pin-ownership modes.
  localparam logic MODE_FLEXIBLE = 1'b0;
  localparam logic MODE_DEDICATED = 1'b1;

  // Active-low output enable levels of a two-way pad.
  localparam logic OE_N_DRIVE = 1'b0;
  localparam logic OE_N_RELEASE = 1'b1;

  // Pull-up control levels.
  localparam logic PULL_ON = 1'b1;
  localparam logic PULL_OFF = 1'b0;

  // Reset value of the synchroniser flops; the pins idle high under pull-ups.
  localparam logic SYNC_RESET = 1'b1;
  localparam logic BIT_CLEAR = 1'b0;

  localparam int TAP_STATE_W = 16;

  typedef enum logic [TAP_STATE_W-1:0] {
    TAP_TLR = 16'h0001,
    TAP_RTI = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SHF_DR = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SHF_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } spoc_tap_state_type;

  // What user logic wants on a shared pad when the pad is user I/O.
  typedef struct packed {
    logic dout;
    logic oe;
  } spoc_pin_drv_type;

  // What the block drives onto a pad.
  typedef struct packed {
    logic dout;
    logic oe_n;
  } spoc_pad_type;

  // Strobes handed to the scan chain logic.
  typedef struct packed {
    logic tck_rise;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
    logic tap_reset;
  } spoc_scan_ctl_type;

endpackage

//--- spoc_tester.sv
// Model of the boundary-scan tester that drives the test clock, mode-select and data-in.
`timescale 1ns/1ps
module spoc_tester (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // One 160 ns test clock period; the clock stands low between steps.
  task automatic step(input logic tms_bit, input logic tdi_bit);
    tms_out = tms_bit;
    tdi_out = tdi_bit;
    #80 tck_out = 1'b1;
    #80 tck_out = 1'b0;
    // The data line has no pull, so a stale level must not linger.
    tdi_out = ~tdi_bit;
  endtask
endmodule

//--- spoc_top.sv
// Scan pin ownership control: test access port controller and shared-pin steering.
`timescale 1ns/1ps

//Contract
// - Two modes; mode-select pin never user I/O.
// - Dedicated mode keeps tck, tms, tdi and tdo scan-owned.
// - Dedicated mode: pull-ups on mode-select and data-in.
// - No reservation chosen means flexible mode.
// - Flexible: controller state picks pin role.
// - Flexible mode applies no pulls on those pins.
// - Power-up puts controller in Test-Logic-Reset.
// - Flexible and Test-Logic-Reset: pins are user I/O.
// - Clock rise with mode-select low enters scan.
// - Five high mode-select cycles return to reset.
// - Reserved test-reset pin is scan reset only.
// - Reserved test-reset pin keeps pull-up enabled.
// - Unreserved test-reset is user I/O, else tristated.
// - Reserved test-reset low forces Test-Logic-Reset.
// - Unreserved test-reset behaves as held high.
module spoc_top #(
  parameter logic RESERVE_JTAG = spoc_pkg::MODE_FLEXIBLE,
  parameter logic RESERVE_TRST = 1'b0,
  parameter logic TRST_USER_USED = 1'b0
) (
  input  wire logic                       ref_clk_in,
  input  wire logic                       arst_n_in,
  input  wire logic                       tck_pad_in,
  input  wire logic                       tms_pad_in,
  input  wire logic                       tdi_pad_in,
  input  wire logic                       tdo_pad_in,
  input  wire logic                       trst_pad_in,
  input  wire spoc_pkg::spoc_pin_drv_type tck_user_in,
  input  wire spoc_pkg::spoc_pin_drv_type tdi_user_in,
  input  wire spoc_pkg::spoc_pin_drv_type tdo_user_in,
  input  wire spoc_pkg::spoc_pin_drv_type trst_user_in,
  input  wire logic                       scan_tdo_in,
  output spoc_pkg::spoc_pad_type          tck_pad_out,
  output spoc_pkg::spoc_pad_type          tdi_pad_out,
  output spoc_pkg::spoc_pad_type          tdo_pad_out,
  output spoc_pkg::spoc_pad_type          trst_pad_out,
  output logic                            tms_pullup_out,
  output logic                            tdi_pullup_out,
  output logic                            trst_pullup_out,
  output logic                            scan_owned_out,
  output logic [3:0]                      user_pin_val_out,
  output logic                            scan_tdi_out,
  output spoc_pkg::spoc_scan_ctl_type     scan_ctl_out,
  output spoc_pkg::spoc_tap_state_type    tap_state_out
);

  logic [4:0]                   meta_q;
  logic [4:0]                   sync_q;
  logic                         tck_prev_q;
  logic                         tck_rise;
  logic                         tck_fall;
  logic                         trst_force;
  logic                         scan_owned;
  logic                         tdo_drive;
  logic                         tdo_bit_q;
  spoc_pkg::spoc_tap_state_type tap_q;
  spoc_pkg::spoc_tap_state_type tap_d;

  // Sync order: 0 tck, 1 tms, 2 tdi, 3 tdo, 4 trst. The first stage feeds only the second.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= {5{spoc_pkg::SYNC_RESET}};
      sync_q <= {5{spoc_pkg::SYNC_RESET}};
    end else begin
      meta_q <= {trst_pad_in, tdo_pad_in, tdi_pad_in, tms_pad_in, tck_pad_in};
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tck_prev_q <= spoc_pkg::SYNC_RESET;
    end else begin
      tck_prev_q <= sync_q[0];
    end
  end

  assign tck_rise = sync_q[0] & ~tck_prev_q;
  assign tck_fall = ~sync_q[0] & tck_prev_q;

  // An unreserved test-reset pin never resets the controller, as if held high.
  assign trst_force = RESERVE_TRST & ~sync_q[4];

  // TMS is sampled on each detected TCK rise; five high samples reach reset from anywhere.
  always_comb begin
    tap_d = tap_q;
    if (tck_rise) begin
      case (tap_q)
        spoc_pkg::TAP_TLR: tap_d = sync_q[1] ? spoc_pkg::TAP_TLR : spoc_pkg::TAP_RTI;
        spoc_pkg::TAP_RTI: tap_d = sync_q[1] ? spoc_pkg::TAP_SEL_DR : spoc_pkg::TAP_RTI;
        spoc_pkg::TAP_SEL_DR: tap_d = sync_q[1] ? spoc_pkg::TAP_SEL_IR : spoc_pkg::TAP_CAP_DR;
        spoc_pkg::TAP_CAP_DR: tap_d = sync_q[1] ? spoc_pkg::TAP_EX1_DR : spoc_pkg::TAP_SHF_DR;
        spoc_pkg::TAP_SHF_DR: tap_d = sync_q[1] ? spoc_pkg::TAP_EX1_DR : spoc_pkg::TAP_SHF_DR;
        spoc_pkg::TAP_EX1_DR: tap_d = sync_q[1] ? spoc_pkg::TAP_UPD_DR : spoc_pkg::TAP_PAU_DR;
        spoc_pkg::TAP_PAU_DR: tap_d = sync_q[1] ? spoc_pkg::TAP_EX2_DR : spoc_pkg::TAP_PAU_DR;
        spoc_pkg::TAP_EX2_DR: tap_d = sync_q[1] ? spoc_pkg::TAP_UPD_DR : spoc_pkg::TAP_SHF_DR;
        spoc_pkg::TAP_UPD_DR: tap_d = sync_q[1] ? spoc_pkg::TAP_SEL_DR : spoc_pkg::TAP_RTI;
        spoc_pkg::TAP_SEL_IR: tap_d = sync_q[1] ? spoc_pkg::TAP_TLR : spoc_pkg::TAP_CAP_IR;
        spoc_pkg::TAP_CAP_IR: tap_d = sync_q[1] ? spoc_pkg::TAP_EX1_IR : spoc_pkg::TAP_SHF_IR;
        spoc_pkg::TAP_SHF_IR: tap_d = sync_q[1] ? spoc_pkg::TAP_EX1_IR : spoc_pkg::TAP_SHF_IR;
        spoc_pkg::TAP_EX1_IR: tap_d = sync_q[1] ? spoc_pkg::TAP_UPD_IR : spoc_pkg::TAP_PAU_IR;
        spoc_pkg::TAP_PAU_IR: tap_d = sync_q[1] ? spoc_pkg::TAP_EX2_IR : spoc_pkg::TAP_PAU_IR;
        spoc_pkg::TAP_EX2_IR: tap_d = sync_q[1] ? spoc_pkg::TAP_UPD_IR : spoc_pkg::TAP_SHF_IR;
        spoc_pkg::TAP_UPD_IR: tap_d = sync_q[1] ? spoc_pkg::TAP_SEL_DR : spoc_pkg::TAP_RTI;
        default: tap_d = spoc_pkg::TAP_TLR;
      endcase
    end
    if (trst_force) begin
      tap_d = spoc_pkg::TAP_TLR;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tap_q <= spoc_pkg::TAP_TLR;
    end else begin
      tap_q <= tap_d;
    end
  end

  // Ownership follows the registered state, so pads flip one cycle after the state.
  assign scan_owned = (RESERVE_JTAG == spoc_pkg::MODE_DEDICATED) |
                      (tap_q != spoc_pkg::TAP_TLR);
  assign tdo_drive = (tap_q == spoc_pkg::TAP_SHF_DR) | (tap_q == spoc_pkg::TAP_SHF_IR);

  // Scan data leaves on the falling TCK edge, so the tester samples a settled bit.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tdo_bit_q <= spoc_pkg::BIT_CLEAR;
    end else if (tck_fall) begin
      tdo_bit_q <= scan_tdo_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tck_pad_out <= '{dout: spoc_pkg::BIT_CLEAR, oe_n: spoc_pkg::OE_N_RELEASE};
      tdi_pad_out <= '{dout: spoc_pkg::BIT_CLEAR, oe_n: spoc_pkg::OE_N_RELEASE};
      tdo_pad_out <= '{dout: spoc_pkg::BIT_CLEAR, oe_n: spoc_pkg::OE_N_RELEASE};
    end else if (scan_owned) begin
      // Scan-owned TCK and TDI are inputs; TDO drives only while shifting.
      tck_pad_out <= '{dout: spoc_pkg::BIT_CLEAR, oe_n: spoc_pkg::OE_N_RELEASE};
      tdi_pad_out <= '{dout: spoc_pkg::BIT_CLEAR, oe_n: spoc_pkg::OE_N_RELEASE};
      tdo_pad_out <= '{dout: tdo_bit_q,
                       oe_n: tdo_drive ? spoc_pkg::OE_N_DRIVE : spoc_pkg::OE_N_RELEASE};
    end else begin
      // user logic owns the three shared pads.
      tck_pad_out <= '{dout: tck_user_in.dout, oe_n: ~tck_user_in.oe};
      tdi_pad_out <= '{dout: tdi_user_in.dout, oe_n: ~tdi_user_in.oe};
      tdo_pad_out <= '{dout: tdo_user_in.dout, oe_n: ~tdo_user_in.oe};
    end
  end

  // A reserved test-reset pad is never driven; an unused user one stays tristated.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trst_pad_out <= '{dout: spoc_pkg::BIT_CLEAR, oe_n: spoc_pkg::OE_N_RELEASE};
    end else if (RESERVE_TRST || !TRST_USER_USED) begin
      trst_pad_out <= '{dout: spoc_pkg::BIT_CLEAR, oe_n: spoc_pkg::OE_N_RELEASE};
    end else begin
      trst_pad_out <= '{dout: trst_user_in.dout, oe_n: ~trst_user_in.oe};
    end
  end

  // Pull-ups are fixed by the build choice and never depend on the controller state.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tms_pullup_out <= spoc_pkg::PULL_OFF;
      tdi_pullup_out <= spoc_pkg::PULL_OFF;
      trst_pullup_out <= spoc_pkg::PULL_OFF;
    end else begin
      tms_pullup_out <= (RESERVE_JTAG == spoc_pkg::MODE_DEDICATED) ?
                        spoc_pkg::PULL_ON : spoc_pkg::PULL_OFF;
      tdi_pullup_out <= (RESERVE_JTAG == spoc_pkg::MODE_DEDICATED) ?
                        spoc_pkg::PULL_ON : spoc_pkg::PULL_OFF;
      trst_pullup_out <= RESERVE_TRST ? spoc_pkg::PULL_ON : spoc_pkg::PULL_OFF;
    end
  end

  // TMS has no user path at all; user logic sees only tck, tdi, tdo and trst values.
  // An unreserved test-reset pad stays user I/O even while the scan pins are owned.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      user_pin_val_out <= 4'h0;
      scan_tdi_out <= spoc_pkg::BIT_CLEAR;
    end else begin
      user_pin_val_out <= {sync_q[4] & ~RESERVE_TRST,
                           scan_owned ? 3'h0 : {sync_q[3:2], sync_q[0]}};
      scan_tdi_out <= sync_q[2];
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan_owned_out <= spoc_pkg::BIT_CLEAR;
      tap_state_out <= spoc_pkg::TAP_TLR;
    end else begin
      scan_owned_out <= scan_owned;
      tap_state_out <= tap_q;
    end
  end

  // Each strobe but tap_reset marks a detected TCK rise in the state that the rise leaves; tap_reset is high throughout TAP_TLR.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan_ctl_out <= '0;
    end else begin
      scan_ctl_out <= '{tck_rise:   tck_rise & scan_owned,
                        capture_dr: tck_rise & (tap_q == spoc_pkg::TAP_CAP_DR),
                        shift_dr:   tck_rise & (tap_q == spoc_pkg::TAP_SHF_DR),
                        update_dr:  tck_rise & (tap_q == spoc_pkg::TAP_UPD_DR),
                        capture_ir: tck_rise & (tap_q == spoc_pkg::TAP_CAP_IR),
                        shift_ir:   tck_rise & (tap_q == spoc_pkg::TAP_SHF_IR),
                        update_ir:  tck_rise & (tap_q == spoc_pkg::TAP_UPD_IR),
                        tap_reset:  tap_q == spoc_pkg::TAP_TLR};
    end
  end

endmodule

//--- tb_top.sv
// Self-checking bench of the scan pin ownership control against a tester model.
`timescale 1ns/1ps
module tb_top;
  // Next state index per current index, one nibble each, for mode-select low and high.
  localparam logic [63:0] N0 = 64'h1BDDBBA146644311;
  localparam logic [63:0] N1 = 64'h2FEFCC0287855920;
  logic ref_clk_in, arst_n_in, trst_pad_in, scan_tdo_in, tdo_float, tck_pad_in, tms_pad_in;
  logic tdi_pad_in, tms_pullup_out, tdi_pullup_out, trst_pullup_out, scan_owned_out, scan_tdi_out;
  logic [3:0]                   user_pin_val_out;
  logic [3:0]                   idx;
  spoc_pkg::spoc_pin_drv_type   tck_user_in, tdi_user_in, tdo_user_in, trst_user_in;
  spoc_pkg::spoc_pad_type       tck_pad_out, tdi_pad_out, tdo_pad_out, trst_pad_out;
  spoc_pkg::spoc_scan_ctl_type  scan_ctl_out;
  spoc_pkg::spoc_tap_state_type tap_state_out;
  spoc_pkg::spoc_tap_state_type r_state;
  logic [3:0]                   r_user;
  logic [2:0]                   r_pull;
  logic                         r_owned;
  logic                         trst_rsv;
  integer seed = 32'hE5C0F5F1;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  wire logic tdo_pad_in = (tdo_pad_out.oe_n === spoc_pkg::OE_N_DRIVE) ? tdo_pad_out.dout : tdo_float;
  spoc_tester i_tst (.tck_out(tck_pad_in), .tms_out(tms_pad_in), .tdi_out(tdi_pad_in));
  spoc_top i_dut (.ref_clk_in, .arst_n_in, .tck_pad_in, .tms_pad_in, .tdi_pad_in, .tdo_pad_in,
    .trst_pad_in, .tck_user_in, .tdi_user_in, .tdo_user_in, .trst_user_in, .scan_tdo_in,
    .tck_pad_out, .tdi_pad_out, .tdo_pad_out, .trst_pad_out, .tms_pullup_out, .tdi_pullup_out,
    .trst_pullup_out, .scan_owned_out, .user_pin_val_out, .scan_tdi_out, .scan_ctl_out,
    .tap_state_out);
  // Second build: dedicated pins and a reserved test-reset pin held by the board.
  spoc_top #(.RESERVE_JTAG(spoc_pkg::MODE_DEDICATED), .RESERVE_TRST(1'b1),
    .TRST_USER_USED(1'b0)) i_dut_rsv (.ref_clk_in, .arst_n_in, .tck_pad_in, .tms_pad_in,
    .tdi_pad_in, .tdo_pad_in(tdo_float), .trst_pad_in(trst_rsv), .tck_user_in, .tdi_user_in,
    .tdo_user_in, .trst_user_in, .scan_tdo_in, .tck_pad_out(), .tdi_pad_out(), .tdo_pad_out(),
    .trst_pad_out(), .tms_pullup_out(r_pull[2]), .tdi_pullup_out(r_pull[1]),
    .trst_pullup_out(r_pull[0]), .scan_owned_out(r_owned), .user_pin_val_out(r_user),
    .scan_tdi_out(), .scan_ctl_out(), .tap_state_out(r_state));
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  // The unreserved reset pad toggles at random and must be ignored.
  always @(posedge ref_clk_in) begin
    #1;
    {tck_user_in, tdi_user_in, tdo_user_in, trst_user_in, scan_tdo_in, trst_pad_in} =
      10'($random(seed));
    tdo_float = ~tdo_float;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [3:0] nxt(input logic [3:0] s, input logic m);
    nxt = m ? N1[s*4+:4] : N0[s*4+:4];
  endfunction
  task automatic walk(input logic m);
    logic b;
    b = 1'($random(seed));
    idx = nxt(idx, m);
    i_tst.step(m, b);
    check(tap_state_out, 16'h0001 << idx);
    check(r_state, trst_rsv ? 16'h0001 << idx : 16'h0001);
    check({r_owned, r_user}, 5'h10);
    check(scan_owned_out, idx != 4'h0);
    if (idx != 4'h0) begin
      check(user_pin_val_out[2:0], 3'h0);
      check({tck_pad_out.oe_n, tdi_pad_out.oe_n}, 2'b11);
      check(tdo_pad_out.oe_n, !(idx == 4'h4 || idx == 4'hB));
    end else begin
      check(user_pin_val_out[1], b);
    end
  endtask
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial begin
    arst_n_in = 1'b0;
    tdo_float = 1'b0;
    trst_rsv = 1'b0;
    {tck_user_in, tdi_user_in, tdo_user_in, trst_user_in, scan_tdo_in, trst_pad_in} = '0;
    repeat (8) @(posedge ref_clk_in);
    #1 check({tck_pad_out.oe_n, tdo_pad_out.oe_n, tap_state_out}, 18'h3_0001);
    arst_n_in = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #1 check({tms_pullup_out, tdi_pullup_out, trst_pullup_out}, 3'b000);
    check({r_pull, r_owned}, 4'hF);
    check(scan_owned_out, 1'b0);
    idx = 4'h0;
    // Four high steps after a shift must not leave scan; the fifth does.
    for (int i = 8; i >= 0; i--) walk(1'(9'b010011111 >> i));
    // Scan use: the board lets the reserved test-reset pin go high.
    trst_rsv = 1'b1;
    repeat (60) walk(1'($random(seed)));
    repeat (5) walk(1'b1);
    check(tap_state_out, spoc_pkg::TAP_TLR);
    walk(1'b0);
    trst_rsv = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    #1 check(r_state, spoc_pkg::TAP_TLR);
    check(tap_state_out, spoc_pkg::TAP_RTI);
    arst_n_in = 1'b0;
    #40 check({scan_owned_out, tap_state_out}, 17'h0_0001);
    check({r_owned, r_state}, 17'h0_0001);
    @(posedge ref_clk_in);
    #1 arst_n_in = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #1 check({scan_owned_out, r_owned, tap_state_out}, 18'h1_0001);
    idx = 4'h0;
    walk(1'b0);
    conclude();
  end
endmodule
